// [rtl/led_seq_pkg.sv]
// Constants and carrier types for the front-panel status lamp sequencer
`default_nettype none
package led_seq_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned CHANNELS        = 8;
  localparam int unsigned ADDR_SHOW_MS    = 2000;
  localparam int unsigned ADDR_SHOW_CYC   = (CLK_HZ / 1000) * ADDR_SHOW_MS;
  localparam int unsigned STEP_MS_DEF     = 100;
  localparam int unsigned STEP_CYC_DEF    = (CLK_HZ / 1000) * STEP_MS_DEF;
  localparam int unsigned BLINK_MS_DEF    = 250;
  localparam int unsigned BLINK_CYC_DEF   = (CLK_HZ / 1000) * BLINK_MS_DEF;
  localparam int unsigned TIMER_W         = 32;
  localparam logic [2:0]  LAST_CH         = 3'h7;
  localparam logic [7:0]  ALL_OFF         = 8'h00;
  localparam logic [7:0]  ALL_ON          = 8'hFF;

  typedef enum logic {
    VARIANT_RELAY,
    VARIANT_ANALOG
  } variant_t;

  // Live per-channel conditions from the module's own I/O logic
  typedef struct packed {
    logic [7:0] active;
    logic [7:0] supv_fault;
    logic [7:0] drv_pos_fail;
    logic [7:0] drv_neg_fail;
    logic [7:0] misconfig;
    logic [7:0] low_alarm;
    logic [7:0] high_alarm;
    logic [7:0] out_of_range;
  } chan_status_t;

  typedef struct packed {
    logic       green;
    logic       yellow;
    logic [7:0] red;
    logic [7:0] amber;
  } lamps_t;
endpackage
`default_nettype wire

// [rtl/blink_gen.sv]
// Free-running square-wave blink source
`default_nettype none
module blink_gen #(
  parameter int unsigned HALF_CYC = 16
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Blink phase
  output logic      phase_out
);
  import led_seq_pkg::*;

  logic [TIMER_W-1:0] cnt_q, cnt_d;
  logic               phase_q, phase_d;

  always_comb begin
    cnt_d   = cnt_q + 32'h1;
    phase_d = phase_q;
    if (cnt_q >= TIMER_W'(HALF_CYC - 1)) begin
      cnt_d   = '0;
      phase_d = ~phase_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end

  assign phase_out = phase_q;
endmodule
`default_nettype wire

// [rtl/status_led_sequencer.sv]
// Power-up lamp test, address display and run-time status lamp driver
`default_nettype none
// Function
// - On power-up light device green and device yellow before channel lamps.
// - Light red channel lamps one by one, channel 1 to 8, cumulative.
// - After red 8 lit, turn red lamps off one by one, 1 to 8.
// - Then run yellow channel lamps through the same on then off pattern.
// - Then show address: red lamp n lit when address switch n is on.
// - Hold the address display for two seconds.
// - At end of address display turn the device yellow lamp off.
// - Unconfigured: flash all channel yellows together; else show normal status.
// - Relay variant: supervised channel fault lights that channel's yellow and status.
// - Any failed positive or negative driver test lights yellow and status.
// - Device green lamp lit whenever powered; off while resetn_in is low.
// - Device yellow blinks once at power-up; steady when disabled or replace. The code has no replace input: steady only for dev_disabled_in.
// - Relay variant: red lamp steady on while channel circuit active.
// - Blink channel yellow on low power or channel misconfigured.
// - Analog variant: red blinks for low alarm, steady for high alarm.
// - Analog variant: yellow steady while channel input out of range.
module status_led_sequencer
  import led_seq_pkg::*;
#(
  parameter int unsigned STEP_CYC  = STEP_CYC_DEF,
  parameter int unsigned BLINK_CYC = BLINK_CYC_DEF,
  parameter int unsigned SHOW_CYC  = ADDR_SHOW_CYC
) (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  // Module variant and mode
  input  wire led_seq_pkg::variant_t     variant_in,
  input  wire logic                      configured_in,
  input  wire logic                      low_power_in,
  input  wire logic                      dev_disabled_in,
  // Channel conditions
  input  wire led_seq_pkg::chan_status_t chan_in,
  // Address switches from the panel
  input  wire logic [7:0]                addr_sw_in,
  // Lamps and status
  output led_seq_pkg::lamps_t            lamps_out,
  output logic [7:0]                     chan_fault_out,
  output logic                           powerup_done_out
);
  import led_seq_pkg::*;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_RED_ON,
    ST_RED_OFF,
    ST_AMB_ON,
    ST_AMB_OFF,
    ST_ADDR,
    ST_RUN
  } state_t;

  // Address switches come from the panel: two-flop synchroniser
  logic [7:0] sw_meta_q, sw_sync_q;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sw_meta_q <= ALL_OFF;
      sw_sync_q <= ALL_OFF;
    end else begin
      sw_meta_q <= addr_sw_in;
      sw_sync_q <= sw_meta_q;
    end
  end

  logic blink;
  blink_gen #(
    .HALF_CYC (BLINK_CYC)
  ) u_blink (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .phase_out (blink)
  );

  // Thermometer mask of channels 0..idx
  function automatic logic [7:0] upto(input logic [2:0] idx);
    logic [7:0] m;
    m = ALL_OFF;
    for (int i = 0; i < CHANNELS; i++) begin
      m[i] = (3'(i) <= idx);
    end
    return m;
  endfunction

  state_t             st_q, st_d;
  logic [2:0]         ch_q, ch_d;
  logic [TIMER_W-1:0] tmr_q, tmr_d;
  logic [7:0]         addr_q, addr_d;
  logic               done_q, done_d;
  logic               tick;

  assign tick = (tmr_q == '0);

  always_comb begin
    st_d   = st_q;
    ch_d   = ch_q;
    tmr_d  = tick ? TIMER_W'(0) : tmr_q - 32'h1;
    addr_d = addr_q;
    done_d = done_q;
    case (st_q)
      ST_INIT: begin
        // Both device lamps show for one step before channels start
        if (tick) begin
          st_d  = ST_RED_ON;
          tmr_d = TIMER_W'(STEP_CYC - 1);
        end
      end
      ST_RED_ON, ST_RED_OFF, ST_AMB_ON, ST_AMB_OFF: begin
        if (tick) begin
          tmr_d = TIMER_W'(STEP_CYC - 1);
          ch_d  = ch_q + 3'h1;
          if (ch_q == LAST_CH) begin
            ch_d = 3'h0;
            case (st_q)
              ST_RED_ON:  st_d = ST_RED_OFF;
              ST_RED_OFF: st_d = ST_AMB_ON;
              ST_AMB_ON:  st_d = ST_AMB_OFF;
              default: begin
                st_d   = ST_ADDR;
                addr_d = sw_sync_q;
                tmr_d  = TIMER_W'(SHOW_CYC - 1);
              end
            endcase
          end
        end
      end
      ST_ADDR: begin
        if (tick) begin
          st_d   = ST_RUN;
          done_d = 1'b1;
        end
      end
      ST_RUN: begin
        tmr_d = '0;
      end
      default: begin
        st_d = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_q   <= ST_INIT;
      ch_q   <= 3'h0;
      tmr_q  <= TIMER_W'(STEP_CYC - 1);
      addr_q <= ALL_OFF;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      ch_q   <= ch_d;
      tmr_q  <= tmr_d;
      addr_q <= addr_d;
      done_q <= done_d;
    end
  end

  // Lamp computation, registered so outputs come from flops
  lamps_t     lamps_q, lamps_d;
  logic [7:0] fault_q, fault_d;
  logic [7:0] drv_fail, hw_fault;

  assign drv_fail = chan_in.drv_pos_fail | chan_in.drv_neg_fail;
  assign hw_fault = drv_fail |
                    ((variant_in == VARIANT_RELAY) ? chan_in.supv_fault : ALL_OFF);

  always_comb begin
    lamps_d.green  = 1'b1;
    lamps_d.yellow = 1'b1;
    lamps_d.red    = ALL_OFF;
    lamps_d.amber  = ALL_OFF;
    fault_d        = hw_fault;
    case (st_q)
      ST_INIT:    lamps_d.red = ALL_OFF;
      ST_RED_ON:  lamps_d.red = upto(ch_q);
      ST_RED_OFF: lamps_d.red = ~upto(ch_q);
      ST_AMB_ON:  lamps_d.amber = upto(ch_q);
      ST_AMB_OFF: lamps_d.amber = ~upto(ch_q);
      ST_ADDR:    lamps_d.red = addr_q;
      ST_RUN: begin
        lamps_d.yellow = dev_disabled_in;
        if (!configured_in) begin
          lamps_d.amber = blink ? ALL_ON : ALL_OFF;
        end else begin
          // Steady faults outrank the blinking advisories
          for (int i = 0; i < CHANNELS; i++) begin
            if (hw_fault[i]) begin
              lamps_d.amber[i] = 1'b1;
            end else if (variant_in == VARIANT_ANALOG && chan_in.out_of_range[i]) begin
              lamps_d.amber[i] = 1'b1;
            end else if (low_power_in || chan_in.misconfig[i]) begin
              lamps_d.amber[i] = blink;
            end
            if (variant_in == VARIANT_RELAY) begin
              lamps_d.red[i] = chan_in.active[i];
            end else if (chan_in.high_alarm[i]) begin
              lamps_d.red[i] = 1'b1;
            end else begin
              lamps_d.red[i] = chan_in.low_alarm[i] & blink;
            end
          end
        end
      end
      default: lamps_d.yellow = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      lamps_q <= '0;
      fault_q <= ALL_OFF;
    end else begin
      lamps_q <= lamps_d;
      fault_q <= fault_d;
    end
  end

  assign lamps_out        = lamps_q;
  assign chan_fault_out   = fault_q;
  assign powerup_done_out = done_q;

  // Checks
  sequence s_red_last;
    st_q == ST_RED_ON && ch_q == LAST_CH && tick;
  endsequence

  sequence s_run_relay;
    st_q == ST_RUN && configured_in && variant_in == VARIANT_RELAY;
  endsequence

  sequence s_run_analog;
    st_q == ST_RUN && configured_in && variant_in == VARIANT_ANALOG;
  endsequence

  AST_INIT_LAMPS: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_INIT |=> lamps_q.green && lamps_q.yellow && lamps_q.red == ALL_OFF)
    else $error("device lamps not both lit before channel test");

  AST_RED_CUMUL: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_RED_ON |=> lamps_q.red == upto($past(ch_q)))
    else $error("red lamp fill pattern wrong");

  AST_RED_TO_OFF: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_red_last |=> st_q == ST_RED_OFF && ch_q == 3'h0 ##1 lamps_q.red == 8'hFE)
    else $error("red turn-off did not start at channel one");

  AST_AMB_FOLLOWS: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_RED_OFF && ch_q == LAST_CH && tick |=> st_q == ST_AMB_ON)
    else $error("yellow test did not follow red test");

  AST_ADDR_SHOW: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_ADDR |=> lamps_q.red == $past(addr_q))
    else $error("address pattern not shown on red lamps");

  AST_ADDR_TIME: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_ADDR && $past(st_q) != ST_ADDR |-> tmr_q == TIMER_W'(SHOW_CYC - 1))
    else $error("address hold time wrong");

  AST_FAULT_OFF: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_ADDR && tick |=> done_q ##1 lamps_q.yellow == $past(dev_disabled_in))
    else $error("device yellow not released after address display");

  AST_UNCONF: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_RUN && !configured_in |=> lamps_q.amber == ($past(blink) ? ALL_ON : ALL_OFF))
    else $error("unconfigured flash not common to all channels");

  AST_DRV_FAULT: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (drv_fail != ALL_OFF) |=> (chan_fault_out & $past(drv_fail)) == $past(drv_fail))
    else $error("driver test failure not flagged");

  AST_GREEN: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $past(resetn_in) |-> lamps_q.green)
    else $error("green lamp off while powered");

  AST_DEV_YELLOW: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q != ST_RUN |=> lamps_q.yellow)
    else $error("device yellow not held on through power-up");

  AST_RUN_YELLOW: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_RUN |=> lamps_q.yellow == $past(dev_disabled_in))
    else $error("device yellow does not follow disable state");

  AST_RELAY_FAULT: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_run_relay |=>
      (lamps_q.amber & $past(chan_in.supv_fault)) == $past(chan_in.supv_fault) &&
      (chan_fault_out & $past(chan_in.supv_fault)) == $past(chan_in.supv_fault))
    else $error("supervision fault not shown on yellow and status");

  AST_RELAY_RED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_run_relay |=> lamps_q.red == $past(chan_in.active))
    else $error("relay red lamps do not follow channel activity");

  AST_ADV_BLINK: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_q == ST_RUN && configured_in && low_power_in && hw_fault == ALL_OFF &&
    chan_in.out_of_range == ALL_OFF |=> lamps_q.amber == ($past(blink) ? ALL_ON : ALL_OFF))
    else $error("low power advisory not blinking");

  AST_HIGH_ALARM: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_run_analog |=>
      (lamps_q.red & $past(chan_in.high_alarm)) == $past(chan_in.high_alarm))
    else $error("high alarm red lamp not steady");

  AST_LOW_ALARM: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_run_analog |=> (lamps_q.red & ~$past(chan_in.high_alarm)) ==
      (($past(chan_in.low_alarm) & ($past(blink) ? ALL_ON : ALL_OFF)) &
       ~$past(chan_in.high_alarm)))
    else $error("low alarm red lamp not blinking");

  AST_OUT_OF_RANGE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_run_analog |=>
      (lamps_q.amber & $past(chan_in.out_of_range)) == $past(chan_in.out_of_range))
    else $error("out of range yellow lamp not steady");
endmodule
`default_nettype wire

// [bench/panel_model.sv]
// Front-panel model: address switch bank facing the lamp sequencer
`default_nettype none
module panel_model
  import led_seq_pkg::*;
#(
  parameter logic [7:0] SW_SET = 8'hA5
) (
  // Lamps from the block
  input  wire led_seq_pkg::lamps_t lamps_in,
  // Address switches
  output logic [7:0]               addr_sw_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Set before power-up and never moved, so capture timing cannot matter
  assign addr_sw_out = SW_SET;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the status lamp sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import led_seq_pkg::*;
  localparam int unsigned STEP  = 4;
  localparam int unsigned BLINK = 3;
  localparam int unsigned SHOW  = 20;
  localparam logic [7:0]  SW    = 8'hA5;
  logic         clk_in          = 1'b0;
  logic         resetn_in       = 1'b0;
  variant_t     variant_in      = VARIANT_RELAY;
  logic         configured_in   = 1'b1;
  logic         low_power_in    = 1'b0;
  logic         dev_disabled_in = 1'b0;
  chan_status_t chan_in         = '0;
  logic [7:0]   addr_sw_in;
  lamps_t       lamps_out;
  logic [7:0]   chan_fault_out;
  logic         powerup_done_out;
  lamps_t       l_or;
  lamps_t       l_and;
  int           mixed;
  int           num_errors      = 0;
  int           comparisons     = 0;

  always #2 clk_in = ~clk_in;

  status_led_sequencer #(.STEP_CYC(STEP), .BLINK_CYC(BLINK), .SHOW_CYC(SHOW))
    status_led_sequencer_i (.clk_in(clk_in), .resetn_in(resetn_in), .variant_in(variant_in),
    .configured_in(configured_in), .low_power_in(low_power_in),
    .dev_disabled_in(dev_disabled_in), .chan_in(chan_in), .addr_sw_in(addr_sw_in),
    .lamps_out(lamps_out), .chan_fault_out(chan_fault_out),
    .powerup_done_out(powerup_done_out));

  panel_model #(.SW_SET(SW)) panel_model_i (.lamps_in(lamps_out), .addr_sw_out(addr_sw_in));

  task automatic finish_test();
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected {red, amber} for lamp test step i; step 33 is the address
  function automatic logic [15:0] pat(int i);
    if (i == 0) return 16'h0000;
    if (i <= 8) return {8'((9'h001 << i) - 1), 8'h00};
    if (i <= 16) return {8'(8'hFF << (i - 8)), 8'h00};
    if (i <= 24) return {8'h00, 8'((9'h001 << (i - 16)) - 1)};
    if (i <= 32) return {8'h00, 8'(8'hFF << (i - 24))};
    return {SW, 8'h00};
  endfunction

  // Follows every lamp change up to run mode, timing each step after step 0
  task automatic powerup();
    logic [15:0] prev;
    logic [15:0] cur;
    int          idx;
    int          run;
    idx = 0;
    run = 0;
    @(posedge clk_in);
    @(negedge clk_in);
    prev = {lamps_out.red, lamps_out.amber};
    check("init_dev", {lamps_out.green, lamps_out.yellow}, 2'b11);
    check("init_ch", prev, pat(0));
    for (int k = 0; k < 400 && idx < 34; k++) begin
      @(negedge clk_in);
      cur = {lamps_out.red, lamps_out.amber};
      run++;
      if (cur !== prev) begin
        if (idx > 0) check("step_len", run, (idx == 33) ? SHOW : STEP);
        idx++;
        if (idx < 34) check("step_pat", cur, pat(idx));
        prev = cur;
        run = 0;
      end else begin
        check("pu_dev", {lamps_out.green, lamps_out.yellow}, 2'b11);
      end
    end
    check("pu_steps", idx, 34);
    repeat (2) @(negedge clk_in);
    check("pu_done", {powerup_done_out, lamps_out.yellow}, 2'b10);
  endtask

  // Applies one condition set, then gathers lamps over a full blink period
  task automatic run_case(variant_t v, logic cfg, logic lp, logic dis, chan_status_t c);
    @(posedge clk_in);
    variant_in <= v;
    configured_in <= cfg;
    low_power_in <= lp;
    dev_disabled_in <= dis;
    chan_in <= c;
    repeat (4) @(posedge clk_in);
    l_or = '0;
    l_and = '1;
    mixed = 0;
    repeat (8) begin
      @(negedge clk_in);
      l_or = l_or | lamps_out;
      l_and = l_and & lamps_out;
      if (lamps_out.amber !== ALL_OFF && lamps_out.amber !== ALL_ON) mixed++;
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    powerup();
    run_case(VARIANT_RELAY, 1'b1, 1'b0, 1'b0, '{active: 8'h3C, supv_fault: 8'h10,
             drv_pos_fail: 8'h01, drv_neg_fail: 8'h80, default: 8'h00});
    check("relay_red", {l_or.red, l_and.red}, 16'h3C3C);
    check("relay_amb", {l_or.amber, l_and.amber}, 16'h9191);
    check("relay_flt", chan_fault_out, 8'h91);
    // Supervision faults mean nothing to the analog variant
    run_case(VARIANT_ANALOG, 1'b1, 1'b0, 1'b0, '{active: 8'h3C, supv_fault: 8'h10,
             drv_pos_fail: 8'h01, drv_neg_fail: 8'h80, high_alarm: 8'h0F,
             low_alarm: 8'hF0, out_of_range: 8'h02, default: 8'h00});
    check("ana_red", {l_or.red, l_and.red}, 16'hFF0F);
    check("ana_amb", {l_or.amber, l_and.amber}, 16'h8383);
    check("ana_flt", chan_fault_out, 8'h81);
    run_case(VARIANT_RELAY, 1'b1, 1'b0, 1'b0, '{misconfig: 8'h24, drv_pos_fail: 8'h01,
             default: 8'h00});
    check("mis_amb", {l_or.amber, l_and.amber}, 16'h2501);
    run_case(VARIANT_RELAY, 1'b0, 1'b0, 1'b0, '{active: 8'h3C, default: 8'h00});
    check("uncfg", {l_or.red, l_or.amber, l_and.amber}, 24'h00FF00);
    check("uncfg_sync", mixed, 0);
    run_case(VARIANT_RELAY, 1'b1, 1'b1, 1'b1, '0);
    check("lowpwr", {l_or.amber, l_and.amber}, 16'hFF00);
    check("dev_dis", {l_and.green, l_and.yellow}, 2'b11);
    finish_test();
  end

  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
